// >>> rtl/gpio_regs.vh
// register offsets, reset values and timing counts of the port block
`ifndef GPIO_REGS_VH
`define GPIO_REGS_VH
// ****************************************************************
// register indices (printed offset is the index; the byte address is the index times four)
// ****************************************************************
`define PORT_E_DIRECTION_IDX 4'h1
`define PORT_A_DIRECTION_IDX 4'h2
`define PORT_A_VALUE_IDX     4'h3
`define PORT_C_VALUE_IDX     4'h4
`define PORT_B_DIRECTION_IDX 4'h5
`define PORT_B_VALUE_IDX     4'h6
`define PORT_D_DIRECTION_IDX 4'hC
`define PORT_D_VALUE_IDX     4'hD
`define PORT_E_VALUE_IDX     4'hE
`define CONTROL_IDX          4'hF
// ****************************************************************
// reset values and field positions
// ****************************************************************
`define DIR_RESET            4'h0
`define PORT_C_RESET         4'h0
`define CTRL_HALT_BIT        0
`define CTRL_WAKE_BIT        1
`define WAKE_VECTOR          12'h004
// ****************************************************************
// carrier timing
// ****************************************************************
`define CLK_FREQ_HZ          125000000
`define CARRIER_FREQ_HZ      38000
`define CARRIER_HALF_CYCLES  (`CLK_FREQ_HZ / (2 * `CARRIER_FREQ_HZ))
`endif

// >>> rtl/pin_sync.v
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter WIDTH = 4
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;  // first stage, read only by the second
  // ****************************************************************
  // two stages
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/carrier_gen.v
// square wave generator for the port a bit 3 carrier
`timescale 1ns/1ps
`default_nettype none
module carrier_gen #(
  parameter [15:0] HALF_CYCLES = 16'd1644
) (
  input  wire pclk,
  input  wire presetn,
  input  wire clk_en,
  input  wire run,
  output reg  carrier
);
  reg [15:0] count_q;  // cycles into the current half period
  // ****************************************************************
  // divider: stops and parks low when not running
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= 16'h0000;
      carrier <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        count_q <= 16'h0000;
        carrier <= 1'b0;
      end else if (count_q == HALF_CYCLES - 16'd1) begin
        count_q <= 16'h0000;
        carrier <= ~carrier;
      end else begin
        count_q <= count_q + 16'd1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/gpio_ports.v
// five-port gpio block with halt wake-up, apb register access
//
// Operation
// - port a direction at 02h, one is output
// - port a data: read pins, write outputs
// - output bits read back the latch
// - pull-down forced off on output bits
// - input bits read the pin level
// - halt: enabled rising edge wakes system
// - wake-up loads program counter with 004h
// - carrier option: bit3 outputs 38khz when set
// - halt forces port a bit3 low
// - no carrier option: bit3 plain port
// - bit0 schmitt path active after reset
// - port b direction 05h, data 06h
// - port c output only at 04h
// - port d direction 0ch, data 0dh
// - port e io option zero: inputs only
// - port e direction 01h when io option
// - port e structure chosen by three options
// - bit1 read-zero option reads bit1 zero (here only together with comparator one or the amplifier)
// - bit3 read-zero option likewise for bit3 (here only together with comparator two)
// - comparator one replaces port e bit0 read
// - comparator two replaces port e bit2 read
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"
module gpio_ports #(
  parameter [3:0]  WAKE_A_ENABLE  = 4'h0,  // per-bit wake-up option, port a
  parameter [3:0]  WAKE_B_ENABLE  = 4'h0,  // per-bit wake-up option, port b
  parameter [3:0]  PULLDOWN_A     = 4'h0,  // per-bit pull-down options
  parameter [3:0]  PULLDOWN_B     = 4'h0,
  parameter [3:0]  PULLDOWN_D     = 4'h0,
  parameter [3:0]  PULLDOWN_E     = 4'h0,
  parameter        CARRIER_OUTPUT_OPTION = 1'b0,
  parameter        SCHMITT_WAKE_OPTION   = 1'b0,
  parameter        PORT_E_IO_OPTION      = 1'b0,
  parameter        AMPLIFIER_OPTION      = 1'b0,
  parameter        COMPARATOR_ONE_OPTION = 1'b0,
  parameter        COMPARATOR_TWO_OPTION = 1'b0,
  parameter        BIT1_READ_ZERO_OPTION = 1'b0,
  parameter        BIT3_READ_ZERO_OPTION = 1'b0
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // pins: output enables are active low
  input  wire [3:0]  port_a_in,
  output wire [3:0]  port_a_out,
  output wire [3:0]  port_a_oe_n,
  output wire [3:0]  port_a_pulldown,
  input  wire [3:0]  port_b_in,
  output wire [3:0]  port_b_out,
  output wire [3:0]  port_b_oe_n,
  output wire [3:0]  port_b_pulldown,
  output wire [3:0]  port_c_out,
  input  wire [3:0]  port_d_in,
  output wire [3:0]  port_d_out,
  output wire [3:0]  port_d_oe_n,
  output wire [3:0]  port_d_pulldown,
  input  wire [3:0]  port_e_in,
  output wire [3:0]  port_e_out,
  output wire [3:0]  port_e_oe_n,
  output wire [3:0]  port_e_pulldown,
  // analog side
  input  wire        comparator_one_in,
  input  wire        comparator_two_in,
  output wire        schmitt_enable,
  output wire        amplifier_enable,
  // core side
  input  wire        halt_enter,
  output wire        halt_mode,
  output reg         wake_pulse,
  output wire [11:0] wake_vector
);
  // ****************************************************************
  // storage
  // ****************************************************************
  reg  [3:0]  dir_a_q, dir_b_q, dir_d_q, dir_e_q;  // one = output
  reg  [3:0]  val_a_q, val_b_q, val_c_q, val_d_q, val_e_q;  // output latches
  reg         halt_q;           // core sleeping
  reg         wake_seen_q;      // sticky: last halt ended by a pin
  reg  [7:0]  prev_ab_q;        // last sampled a/b levels for edge detect
  reg         schmitt_q;        // schmitt path enable, set after reset
  wire [3:0]  sync_a, sync_b, sync_d, sync_e;
  wire [1:0]  sync_cmp;
  wire        carrier;
  wire [3:0]  dir_e_eff;        // direction as the io option allows
  wire [3:0]  read_a, read_b, read_d, read_e;
  wire [7:0]  wake_mask;
  wire [7:0]  rise;
  wire        wake_hit;
  wire        wr_en;
  wire [3:0]  reg_idx;
  wire        addr_ok;
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  pin_sync #(.WIDTH(18)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in ({comparator_two_in, comparator_one_in,
                port_e_in, port_d_in, port_b_in, port_a_in}),
    .sync_out ({sync_cmp, sync_e, sync_d, sync_b, sync_a})
  );
  // ****************************************************************
  // carrier generator
  // ****************************************************************
  // full-width divider figure, cut on purpose to the generator's counter
  localparam [31:0] CARRIER_HALF = `CARRIER_HALF_CYCLES;
  carrier_gen #(.HALF_CYCLES(CARRIER_HALF[15:0])) u_carrier (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .run     (CARRIER_OUTPUT_OPTION && dir_a_q[3] && val_a_q[3] && !halt_q),
    .carrier (carrier)
  );
  // ****************************************************************
  // apb decode
  // ****************************************************************
  assign pready  = 1'b1;  // zero wait states
  assign pslverr = psel && penable && !addr_ok;  // unmapped word errors
  assign reg_idx = paddr[5:2];
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) &&
                   (reg_idx != 4'h0) && (reg_idx != 4'h7) && (reg_idx != 4'h8) &&
                   (reg_idx != 4'h9) && (reg_idx != 4'hA) && (reg_idx != 4'hB);
  // ****************************************************************
  // read muxing: outputs read latch, inputs read pin
  // ****************************************************************
  assign read_a = (dir_a_q & val_a_q) | (~dir_a_q & sync_a);
  assign read_b = (dir_b_q & val_b_q) | (~dir_b_q & sync_b);
  assign read_d = (dir_d_q & val_d_q) | (~dir_d_q & sync_d);
  // io option off: direction register has no effect, all inputs
  assign dir_e_eff = PORT_E_IO_OPTION ? dir_e_q : 4'h0;
  // port e: comparators take bits 0/2, read-zero options mask 1/3
  // amplifier with comparator one reads bits 2/3 zero: they are analog
  wire [3:0] e_raw = (dir_e_eff & val_e_q) | (~dir_e_eff & sync_e);
  assign read_e[0] = COMPARATOR_ONE_OPTION ? sync_cmp[0] : e_raw[0];
  assign read_e[1] = ((COMPARATOR_ONE_OPTION || AMPLIFIER_OPTION) &&
                      BIT1_READ_ZERO_OPTION) ? 1'b0 : e_raw[1];
  assign read_e[2] = (AMPLIFIER_OPTION && COMPARATOR_ONE_OPTION) ? 1'b0 :
                     COMPARATOR_TWO_OPTION ? sync_cmp[1] : e_raw[2];
  assign read_e[3] = (AMPLIFIER_OPTION && COMPARATOR_ONE_OPTION) ? 1'b0 :
                     (COMPARATOR_TWO_OPTION && BIT3_READ_ZERO_OPTION) ? 1'b0 :
                     e_raw[3];
  assign amplifier_enable = AMPLIFIER_OPTION;
  // ****************************************************************
  // read data register: combinational mux into a flop at setup
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable) begin
      case (reg_idx)
        `PORT_E_DIRECTION_IDX: prdata <= {28'h000_0000, dir_e_q};
        `PORT_A_DIRECTION_IDX: prdata <= {28'h000_0000, dir_a_q};
        `PORT_A_VALUE_IDX:     prdata <= {28'h000_0000, read_a};
        `PORT_C_VALUE_IDX:     prdata <= {28'h000_0000, val_c_q};
        `PORT_B_DIRECTION_IDX: prdata <= {28'h000_0000, dir_b_q};
        `PORT_B_VALUE_IDX:     prdata <= {28'h000_0000, read_b};
        `PORT_D_DIRECTION_IDX: prdata <= {28'h000_0000, dir_d_q};
        `PORT_D_VALUE_IDX:     prdata <= {28'h000_0000, read_d};
        `PORT_E_VALUE_IDX:     prdata <= {28'h000_0000, read_e};
        `CONTROL_IDX:          prdata <= {30'h0000_0000, wake_seen_q, halt_q};
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end
  // ****************************************************************
  // register writes
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_a_q <= `DIR_RESET;
      dir_b_q <= `DIR_RESET;
      dir_d_q <= `DIR_RESET;
      dir_e_q <= `DIR_RESET;
      val_c_q <= `PORT_C_RESET;
      // value latches are undefined after reset; zero is chosen here
      val_a_q <= 4'h0;
      val_b_q <= 4'h0;
      val_d_q <= 4'h0;
      val_e_q <= 4'h0;
    end else if (clk_en && wr_en) begin
      case (reg_idx)
        `PORT_E_DIRECTION_IDX: dir_e_q <= pwdata[3:0];
        `PORT_A_DIRECTION_IDX: dir_a_q <= pwdata[3:0];
        `PORT_A_VALUE_IDX:     val_a_q <= pwdata[3:0];
        `PORT_C_VALUE_IDX:     val_c_q <= pwdata[3:0];
        `PORT_B_DIRECTION_IDX: dir_b_q <= pwdata[3:0];
        `PORT_B_VALUE_IDX:     val_b_q <= pwdata[3:0];
        `PORT_D_DIRECTION_IDX: dir_d_q <= pwdata[3:0];
        `PORT_D_VALUE_IDX:     val_d_q <= pwdata[3:0];
        `PORT_E_VALUE_IDX:     val_e_q <= pwdata[3:0];
        default:               ;
      endcase
    end
  end
  // ****************************************************************
  // halt and wake-up
  // ****************************************************************
  assign wake_mask = {WAKE_B_ENABLE, WAKE_A_ENABLE};
  // edge against previous sample; sampling goes on during halt since
  // this block keeps its own clock while the core one stops
  assign rise      = {sync_b, sync_a} & ~prev_ab_q & wake_mask;
  assign wake_hit  = halt_q && (rise != 8'h00);
  assign halt_mode = halt_q;
  assign wake_vector = `WAKE_VECTOR;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q      <= 1'b0;
      wake_seen_q <= 1'b0;
      prev_ab_q   <= 8'h00;
      wake_pulse  <= 1'b0;
    end else if (clk_en) begin
      prev_ab_q  <= {sync_b, sync_a};
      wake_pulse <= wake_hit;
      if (wake_hit) begin
        halt_q      <= 1'b0;
        wake_seen_q <= 1'b1;
      end else if (halt_enter) begin
        halt_q      <= 1'b1;
        wake_seen_q <= 1'b0;
      end else if (wr_en && reg_idx == `CONTROL_IDX && pwdata[`CTRL_WAKE_BIT]) begin
        wake_seen_q <= 1'b0;  // write one clears
      end
    end
  end
  // ****************************************************************
  // schmitt path: switched on in the first cycle after reset release
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      schmitt_q <= 1'b0;
    end else if (clk_en) begin
      schmitt_q <= SCHMITT_WAKE_OPTION;
    end
  end
  assign schmitt_enable = schmitt_q;
  // ****************************************************************
  // pin drive
  // ****************************************************************
  assign port_a_oe_n = ~dir_a_q;
  // bit 3: carrier when the option is on, low in halt, else latch
  assign port_a_out[2:0] = val_a_q[2:0];
  assign port_a_out[3] = halt_q ? 1'b0 :
                         CARRIER_OUTPUT_OPTION ? carrier :
                         val_a_q[3];
  assign port_b_oe_n = ~dir_b_q;
  assign port_b_out  = val_b_q;
  assign port_c_out  = val_c_q;
  assign port_d_oe_n = ~dir_d_q;
  assign port_d_out  = val_d_q;
  assign port_e_oe_n = ~dir_e_eff;
  assign port_e_out  = val_e_q;
  // pull-downs only on input bits
  assign port_a_pulldown = PULLDOWN_A & ~dir_a_q;
  assign port_b_pulldown = PULLDOWN_B & ~dir_b_q;
  assign port_d_pulldown = PULLDOWN_D & ~dir_d_q;
  assign port_e_pulldown = PULLDOWN_E & ~dir_e_eff;
endmodule
`default_nettype wire

// >>> bench/pin_board.sv
// board model: each pin is driven by the device or by the board
`timescale 1ns/1ps
`default_nettype none
module pin_board (
  input  wire logic [3:0] drv,   // device output value
  input  wire logic [3:0] oe_n,  // device enable, low drives
  input  wire logic [3:0] ext,   // level the board forces
  output logic      [3:0] level  // level seen at the pin
);
  // a driven bit shows the device, a released bit the board level
  assign level = (~oe_n & drv) | (oe_n & ext);
endmodule
`default_nettype wire

// >>> bench/gpio_ports_monitor.sv
// assertion checker for the gpio port block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"
module gpio_ports_monitor #(
  parameter [3:0] WAKE_A_ENABLE = 4'h0,
  parameter [3:0] PULLDOWN_A    = 4'h0
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  port_a_in,
  input wire logic [3:0]  port_a_out,
  input wire logic [3:0]  port_a_oe_n,
  input wire logic [3:0]  port_a_pulldown,
  input wire logic [3:0]  port_c_out,
  input wire logic        halt_mode,
  input wire logic        wake_pulse,
  input wire logic [11:0] wake_vector
);
  // ****************************************************************
  // helpers and properties
  // ****************************************************************
  logic [3:0] wd_q;  // write data one cycle back
  wire acc_w = psel && penable && pwrite;  // write access phase
  // a copy of write data lets the register checks look one cycle back
  always_ff @(posedge pclk) wd_q <= pwdata[3:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_dir_a;
    clk_en && acc_w && paddr == {2'b00, `PORT_A_DIRECTION_IDX, 2'b00} |=> port_a_oe_n == ~wd_q;
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("port a enable misses write");
  property p_pull;
    port_a_pulldown == (PULLDOWN_A & port_a_oe_n);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-down on driven bit");
  property p_port_c;
    clk_en && acc_w && paddr == {2'b00, `PORT_C_VALUE_IDX, 2'b00} |=> port_c_out == wd_q;
  endproperty
  a_port_c: assert property (p_port_c) else $error("port c misses write");
  // a low clock enable must hold port c and the port a enables, writes included
  property p_freeze;
    !clk_en |=> $stable(port_c_out) && $stable(port_a_oe_n);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");
  property p_halt_low;
    halt_mode |-> !port_a_out[3];
  endproperty
  a_halt_low: assert property (p_halt_low) else $error("bit3 high in halt");
  property p_wake_one;
    wake_pulse |=> !wake_pulse;
  endproperty
  a_wake_one: assert property (p_wake_one) else $error("wake pulse too long");
  property p_wake_exit;
    wake_pulse |-> $past(halt_mode) && !halt_mode;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("wake outside halt");
  property p_vector;
    wake_pulse |-> wake_vector == 12'h004;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong wake vector");
  property p_wake_edge;
    halt_mode && WAKE_A_ENABLE[0] && $rose(port_a_in[0]) |-> ##[1:5] wake_pulse;
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("rising pin did not wake");
endmodule
bind gpio_ports gpio_ports_monitor #(.WAKE_A_ENABLE(WAKE_A_ENABLE), .PULLDOWN_A(PULLDOWN_A))
  i_gpio_ports_monitor (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .port_a_in(port_a_in),
  .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n), .port_a_pulldown(port_a_pulldown),
  .port_c_out(port_c_out), .halt_mode(halt_mode), .wake_pulse(wake_pulse),
  .wake_vector(wake_vector));
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the gpio port block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_regs.vh"
module tb;
  // ****************************************************************
  // stimulus, design and board
  // ****************************************************************
  logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic halt_enter = 1'b0, cmp1 = 1'b0, cmp2 = 1'b0, clk_en = 1'b1, err;
  // build options of the instance under test
  localparam logic [3:0] WAKE_A = 4'h1, PD_A = 4'hF, PD_B = 4'h3;
  localparam logic       OPT_ON = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, rdata;
  logic [3:0]  ext_a = 4'h0, ext_b = 4'h0, ext_d = 4'h0, ext_e = 4'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, halt_mode, wake_pulse, schm;
  wire  [11:0] wake_vector;
  wire  [3:0]  a_in, a_out, a_oe_n, a_pd, b_in, b_out, b_oe_n, b_pd, c_out;
  wire  [3:0]  d_in, d_out, d_oe_n, e_in, e_out, e_oe_n;
  int          error_cnt = 0, checks_done = 0;
  localparam logic [3:0] RST_IDX [5] = '{4'h1, 4'h2, 4'h5, 4'hC, 4'h4};  // reset-zero regs
  localparam logic [3:0] DIR_IDX [3] = '{4'h2, 4'h5, 4'hC};  // data sits one index up
  gpio_ports #(.WAKE_A_ENABLE(WAKE_A), .PULLDOWN_A(PD_A), .PULLDOWN_B(PD_B),
    .CARRIER_OUTPUT_OPTION(OPT_ON), .SCHMITT_WAKE_OPTION(OPT_ON), .PORT_E_IO_OPTION(OPT_ON),
    .COMPARATOR_ONE_OPTION(OPT_ON), .BIT1_READ_ZERO_OPTION(OPT_ON)) i_gpio_ports (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oe_n),
    .port_a_pulldown(a_pd), .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oe_n),
    .port_b_pulldown(b_pd), .port_c_out(c_out), .port_d_in(d_in), .port_d_out(d_out),
    .port_d_oe_n(d_oe_n), .port_d_pulldown(), .port_e_in(e_in), .port_e_out(e_out),
    .port_e_oe_n(e_oe_n), .port_e_pulldown(), .comparator_one_in(cmp1),
    .comparator_two_in(cmp2), .schmitt_enable(schm), .amplifier_enable(),
    .halt_enter(halt_enter), .halt_mode(halt_mode), .wake_pulse(wake_pulse),
    .wake_vector(wake_vector));
  pin_board i_pin_board_a (.drv(a_out), .oe_n(a_oe_n), .ext(ext_a), .level(a_in));
  pin_board i_pin_board_b (.drv(b_out), .oe_n(b_oe_n), .ext(ext_b), .level(b_in));
  pin_board i_pin_board_d (.drv(d_out), .oe_n(d_oe_n), .ext(ext_d), .level(d_in));
  pin_board i_pin_board_e (.drv(e_out), .oe_n(e_oe_n), .ext(ext_e), .level(e_in));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // direction and port c registers come out of reset at zero
  task automatic t_reset;
    foreach (RST_IDX[i]) begin
      apb(1'b0, RST_IDX[i], 32'h0000_0000);
      chk(rdata, 32'h0000_0000);
    end
    chk(a_oe_n, 4'hF);
    chk(e_oe_n, 4'hF);
    chk(schm, 1'b1);
  endtask
  // mixed directions: driven bits read the latch, released bits the pin
  task automatic t_ports;
    ext_a <= 4'h5;
    ext_b <= 4'h5;
    ext_d <= 4'h5;
    foreach (DIR_IDX[i]) begin
      apb(1'b1, DIR_IDX[i], 32'h0000_0006);
      apb(1'b1, DIR_IDX[i] + 4'h1, 32'h0000_000a);
      apb(1'b0, DIR_IDX[i] + 4'h1, 32'h0000_0000);
      chk(rdata, 32'h0000_0003);
    end
    chk(a_pd, 4'h9);
    chk(b_pd, 4'h1);
    chk(d_out & ~d_oe_n, 4'h2);
  endtask
  // port c drives its pins; an unmapped index is refused
  task automatic t_port_c;
    apb(1'b1, `PORT_C_VALUE_IDX, 32'h0000_0009);
    @(negedge pclk);
    chk(c_out, 4'h9);
    apb(1'b0, 4'h7, 32'h0000_0000);
    chk({err, rdata[30:0]}, 32'h8000_0000);
  endtask
  // clock enable low freezes every register: a port c write is lost
  task automatic t_freeze;
    clk_en <= 1'b0;
    apb(1'b1, `PORT_C_VALUE_IDX, 32'h0000_0006);
    @(negedge pclk);
    chk(c_out, 4'h9);
    @(posedge pclk);
    clk_en <= 1'b1;
  endtask
  // port e: comparator on bit0, bit1 reads zero, bit1 kept input by software
  task automatic t_port_e;
    ext_e <= 4'h3;
    cmp1  <= 1'b1;
    cmp2  <= 1'b1;
    apb(1'b1, `PORT_E_DIRECTION_IDX, 32'h0000_0008);
    apb(1'b1, `PORT_E_VALUE_IDX, 32'h0000_0008);
    apb(1'b0, `PORT_E_VALUE_IDX, 32'h0000_0000);
    chk(rdata, 32'h0000_0009);
    chk(e_oe_n, 4'h7);
    cmp1 <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, `PORT_E_VALUE_IDX, 32'h0000_0000);
    chk(rdata, 32'h0000_0008);
  endtask
  // carrier half period on bit3, then low once the data bit clears
  task automatic t_carrier;
    int n;
    apb(1'b1, `PORT_A_DIRECTION_IDX, 32'h0000_0008);
    apb(1'b1, `PORT_A_VALUE_IDX, 32'h0000_0008);
    @(posedge a_out[3]);
    n = 0;
    while (a_out[3] === 1'b1) begin
      @(negedge pclk);
      n++;
    end
    chk(n - 1, `CARRIER_HALF_CYCLES);
    apb(1'b1, `PORT_A_VALUE_IDX, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    chk(a_out[3], 1'b0);
  endtask
  // halt silences the carrier; a rising enabled pin wakes the core
  task automatic t_halt;
    int n;
    @(posedge pclk);
    ext_a <= 4'h4;
    apb(1'b1, `PORT_A_VALUE_IDX, 32'h0000_0008);
    halt_enter <= 1'b1;
    @(posedge pclk);
    halt_enter <= 1'b0;
    repeat (1700) @(negedge pclk);
    chk({halt_mode, a_out[3]}, 2'b10);
    @(posedge pclk);
    ext_a <= 4'h5;
    n = 0;
    while (wake_pulse !== 1'b1 && n < 10) begin
      @(negedge pclk);
      n++;
    end
    chk({wake_pulse, wake_vector}, {1'b1, 12'h004});
    @(negedge pclk);
    chk({wake_pulse, halt_mode}, 2'b00);
    apb(1'b0, `CONTROL_IDX, 32'h0000_0000);
    chk(rdata, 32'h0000_0002);
  endtask
  // ****************************************************************
  // clock, sequence and watchdog
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_ports;
    t_port_c;
    t_freeze;
    t_port_e;
    t_carrier;
    t_halt;
    finish_test;
  end
  // a hang anywhere above ends here well after the longest expected run
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
